// file: hw/tcc_consts.svh
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCC_OFS_SC    4'h0
`define TCC_OFS_CNTH  4'h4
`define TCC_OFS_CNTL  4'h8
`define TCC_OFS_MOD   4'hC

// ----------------------------------------
// Status/control field positions
// ----------------------------------------
`define TCC_SC_OVF    7
`define TCC_SC_OIE    6
`define TCC_SC_CAS    5
`define TCC_SC_CKS_HI 4
`define TCC_SC_CKS_LO 3
`define TCC_SC_PS_HI  2
`define TCC_SC_PS_LO  0

// ----------------------------------------
// Clock source codes
// ----------------------------------------
`define TCC_CKS_OFF   2'h0
`define TCC_CKS_BUS   2'h1
`define TCC_CKS_FIX   2'h2
`define TCC_CKS_EXT   2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCC_SC_RST    8'h00
`define TCC_CNT_RST   16'h0000
`define TCC_MOD_RST   16'h0000

`endif

// file: hw/tcc_pkg.sv
package tcc_pkg;

    // Bus handshake state, Gray along idle -> ack
    typedef enum logic {
        TCC_IDLE = 1'b0,
        TCC_ACK  = 1'b1
    } tcc_bus_e;

    // Decoded register select
    typedef enum logic [2:0] {
        TCC_SEL_NONE = 3'h0,
        TCC_SEL_SC   = 3'h1,
        TCC_SEL_CNTH = 3'h2,
        TCC_SEL_CNTL = 3'h3,
        TCC_SEL_MOD  = 3'h4
    } tcc_sel_e;

endpackage : tcc_pkg

// file: hw/tcc_core.sv
// Notes on behaviour
// RQ1: Overflow flag sets when the counter wraps to zero after the modulo value.
// RQ2: Flag clears only by a status read with flag set, then a zero write.
// RQ3: An overflow between that read and write restarts the clear sequence.
// RQ4: Writing one to the flag leaves it; reset clears it.
// RQ5: Interrupt request is flag and enable together; reset clears enable.
// RQ6: Centre select off counts up only; on counts up and down.
// RQ7: Source 00 none, 01 bus, 10 fixed clock, 11 external.
// RQ8: Without a fixed clock the fixed selection acts like the bus clock.
// RQ9: External source is synchronised to the bus clock before use.
// RQ10: Prescale divides by two to the field value, 1 up to 128.
// RQ11: Prescaler divides whichever source is currently selected.
// RQ12: A new prescale value acts on the cycle after the register update.
// RQ13: Reading one counter byte latches both; the other comes from the latch.
// RQ14: Reset or any status write releases the counter read latch.
// RQ15: Any counter byte write clears the counter and the read latch.
// RQ16: Reset clears the whole counter.
// RQ17: In debug the counter holds and reads return the held value.
// RQ18: In debug counter reads leave the read latch state untouched.
// RQ19: In debug status or counter writes still release the read latch.
// RQ20: After the modulo value the count restarts at zero; modulo zero runs free.
// RQ21: Up/down mode counts to modulo, back to zero, and shows direction.
// RQ22: Count value and a one-cycle overflow event go to the channels.
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`include "tcc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module tcc_core #(
    parameter int CW            = 16,
    parameter int PSW           = 3,
    parameter bit HAS_FIXED_CLK = 1'b0
) (
    input  wire logic          CLOCK,
    input  wire logic          RST_N,
    input  wire logic [3:0]    AVS_ADDRESS,
    input  wire logic          AVS_READ,
    input  wire logic          AVS_WRITE,
    input  wire logic [31:0]   AVS_WRITEDATA,
    input  wire logic [3:0]    AVS_BYTEENABLE,
    output var  logic [31:0]   AVS_READDATA,
    output var  logic          AVS_WAITREQUEST,
    input  wire logic          DEBUG_ACTIVE,
    input  wire logic          FIXED_CLK_TICK,
    input  wire logic          EXT_CLK,
    output var  logic [CW-1:0] COUNT,
    output var  logic          COUNT_DOWN,
    output var  logic          OVERFLOW_EVENT,
    output var  logic          OVERFLOW_IRQ,
    output var  logic          CENTER_ALIGN
);

    localparam int PDW = (1 << PSW) - 1;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic tcc_pkg::tcc_sel_e dec(input logic [3:0] a);
        case (a)
            `TCC_OFS_SC:   dec = tcc_pkg::TCC_SEL_SC;
            `TCC_OFS_CNTH: dec = tcc_pkg::TCC_SEL_CNTH;
            `TCC_OFS_CNTL: dec = tcc_pkg::TCC_SEL_CNTL;
            `TCC_OFS_MOD:  dec = tcc_pkg::TCC_SEL_MOD;
            default:       dec = tcc_pkg::TCC_SEL_NONE;
        endcase
    endfunction : dec

    function automatic logic [7:0] pick(input logic [CW-1:0] v, input logic hi);
        pick = hi ? v[15:8] : v[7:0];
    endfunction : pick

    // ----------------------------------------
    // State
    // ----------------------------------------
    tcc_pkg::tcc_bus_e st_q, st_d;
    logic              wait_q, wait_d;
    logic [31:0]       rdat_q, rdat_d;
    logic              ovf_q, ovf_d;
    logic              arm_q, arm_d;
    logic              oie_q, oie_d;
    logic              cas_q, cas_d;
    logic [1:0]        cks_q, cks_d;
    logic [PSW-1:0]    ps_q, ps_d;
    logic [CW-1:0]     mod_q, mod_d;
    logic [CW-1:0]     cnt_q, cnt_d;
    logic              dir_q, dir_d;
    logic [PDW-1:0]    pre_q, pre_d;
    logic              lat_q, lat_d;
    logic              rem_hi_q, rem_hi_d;
    logic [CW-1:0]     buf_q, buf_d;
    logic              evt_q, evt_d;
    logic              irq_q, irq_d;
    logic              ext1_q, ext2_q, ext3_q;
    logic              fix_q;

    logic              take, take_rd, take_wr, wr_sc, wr_cnt, be0;
    tcc_pkg::tcc_sel_e sel;
    logic              src_tick, cnt_tick, wrap;
    logic [PDW-1:0]    pmask;
    logic [CW-1:0]     top;
    logic [7:0]        rbyte;

    // ----------------------------------------
    // Source select and prescale
    // ----------------------------------------
    always_comb begin
        src_tick = 1'b0;
        // RQ7 source select
        case (cks_q)
            `TCC_CKS_OFF: src_tick = 1'b0;
            `TCC_CKS_BUS: src_tick = 1'b1;
            // RQ8 fixed falls back
            `TCC_CKS_FIX: src_tick = HAS_FIXED_CLK ? (FIXED_CLK_TICK & ~fix_q) : 1'b1;
            // RQ9 synced edge
            `TCC_CKS_EXT: src_tick = ext2_q & ~ext3_q;
            default:      src_tick = 1'b0;
        endcase
        // RQ10 power of two
        pmask = PDW'((1 << ps_q) - 1);
        // RQ11 RQ17 gated tick
        cnt_tick = src_tick && ((pre_q & pmask) == pmask) && !DEBUG_ACTIVE;
        top = (mod_q == '0) ? '1 : mod_q;
    end

    // ----------------------------------------
    // Bus taking
    // ----------------------------------------
    always_comb begin
        take    = (AVS_READ || AVS_WRITE) && (st_q == tcc_pkg::TCC_IDLE);
        take_rd = take && AVS_READ;
        take_wr = take && AVS_WRITE;
        sel     = dec(AVS_ADDRESS);
        be0     = AVS_BYTEENABLE[0];
        wr_sc   = take_wr && be0 && (sel == tcc_pkg::TCC_SEL_SC);
        wr_cnt  = take_wr && be0 &&
                  (sel == tcc_pkg::TCC_SEL_CNTH || sel == tcc_pkg::TCC_SEL_CNTL);
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d     = st_q;
        rdat_d   = rdat_q;
        ovf_d    = ovf_q;
        arm_d    = arm_q;
        oie_d    = oie_q;
        cas_d    = cas_q;
        cks_d    = cks_q;
        ps_d     = ps_q;
        mod_d    = mod_q;
        cnt_d    = cnt_q;
        dir_d    = dir_q;
        pre_d    = pre_q;
        lat_d    = lat_q;
        rem_hi_d = rem_hi_q;
        buf_d    = buf_q;
        wrap     = 1'b0;
        rbyte    = 8'h00;

        case (st_q)
            tcc_pkg::TCC_IDLE: if (take) st_d = tcc_pkg::TCC_ACK;
            tcc_pkg::TCC_ACK:  st_d = tcc_pkg::TCC_IDLE;
            default:           st_d = tcc_pkg::TCC_IDLE;
        endcase
        if (src_tick && !DEBUG_ACTIVE) pre_d = PDW'(pre_q + 1'b1);
        if (cnt_tick) begin
            if (!cas_q) begin
                // RQ20 modulo restart
                if (cnt_q == top) begin
                    cnt_d = '0;
                    wrap  = 1'b1;
                end else begin
                    cnt_d = CW'(cnt_q + 1'b1);
                end
                dir_d = 1'b0;
            end else if (!dir_q) begin
                // RQ21 up then down
                if (cnt_q >= top) begin
                    cnt_d = CW'(cnt_q - 1'b1);
                    dir_d = (cnt_q != CW'(1));
                    wrap  = (cnt_q == CW'(1));
                end else begin
                    cnt_d = CW'(cnt_q + 1'b1);
                end
            end else begin
                cnt_d = CW'(cnt_q - 1'b1);
                if (cnt_q == CW'(1)) begin
                    dir_d = 1'b0;
                    wrap  = 1'b1;
                end
            end
        end
        if (take_rd) begin
            case (sel)
                tcc_pkg::TCC_SEL_SC: begin
                    rdat_d = {24'h000000, ovf_q, oie_q, cas_q, cks_q, ps_q};
                    // RQ2 arm clear
                    if (ovf_q) arm_d = 1'b1;
                end
                tcc_pkg::TCC_SEL_CNTH, tcc_pkg::TCC_SEL_CNTL: begin
                    // RQ13 coherent pair
                    rbyte = lat_q ? pick(buf_q, sel == tcc_pkg::TCC_SEL_CNTH)
                                  : pick(cnt_q, sel == tcc_pkg::TCC_SEL_CNTH);
                    rdat_d = {24'h000000, rbyte};
                    // RQ18 debug keeps latch
                    if (!DEBUG_ACTIVE) begin
                        if (!lat_q) begin
                            lat_d    = 1'b1;
                            buf_d    = cnt_q;
                            rem_hi_d = (sel == tcc_pkg::TCC_SEL_CNTL);
                        end else if (rem_hi_q == (sel == tcc_pkg::TCC_SEL_CNTH)) begin
                            lat_d = 1'b0;
                        end
                    end
                end
                tcc_pkg::TCC_SEL_MOD: rdat_d = {16'h0000, mod_q};
                default:              rdat_d = 32'h00000000;
            endcase
        end
        if (wr_sc) begin
            // RQ2 qualified clear
            // RQ4 one is ignored
            if (arm_q && !AVS_WRITEDATA[`TCC_SC_OVF]) ovf_d = 1'b0;
            arm_d = 1'b0;
            // RQ5 enable bit
            oie_d = AVS_WRITEDATA[`TCC_SC_OIE];
            // RQ6 centre select
            cas_d = AVS_WRITEDATA[`TCC_SC_CAS];
            cks_d = AVS_WRITEDATA[`TCC_SC_CKS_HI:`TCC_SC_CKS_LO];
            // RQ12 prescale update
            ps_d  = AVS_WRITEDATA[`TCC_SC_PS_HI:`TCC_SC_PS_LO];
            // RQ14 RQ19 release latch
            lat_d = 1'b0;
        end
        if (take_wr && sel == tcc_pkg::TCC_SEL_MOD) begin
            if (AVS_BYTEENABLE[0]) mod_d[7:0]  = AVS_WRITEDATA[7:0];
            if (AVS_BYTEENABLE[1]) mod_d[15:8] = AVS_WRITEDATA[15:8];
        end
        if (wr_cnt) begin
            // RQ15 clear counter
            cnt_d = '0;
            dir_d = 1'b0;
            pre_d = '0;
            wrap  = 1'b0;
            // RQ19 release latch
            lat_d = 1'b0;
        end
        // RQ1 RQ3 set wins
        if (wrap) begin
            ovf_d = 1'b1;
            arm_d = 1'b0;
        end
        wait_d = (st_d != tcc_pkg::TCC_ACK);
        // RQ22 event pulse
        evt_d  = wrap;
        // RQ5 request level
        irq_d  = ovf_d && oie_d;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            st_q     <= tcc_pkg::TCC_IDLE;
            wait_q   <= 1'b1;
            rdat_q   <= 32'h00000000;
            ovf_q    <= 1'(`TCC_SC_RST >> `TCC_SC_OVF);
            arm_q    <= 1'b0;
            oie_q    <= 1'b0;
            cas_q    <= 1'b0;
            cks_q    <= `TCC_CKS_OFF;
            ps_q     <= '0;
            mod_q    <= `TCC_MOD_RST;
            // RQ16 reset clear
            cnt_q    <= `TCC_CNT_RST;
            dir_q    <= 1'b0;
            pre_q    <= '0;
            lat_q    <= 1'b0;
            rem_hi_q <= 1'b0;
            buf_q    <= `TCC_CNT_RST;
            evt_q    <= 1'b0;
            irq_q    <= 1'b0;
            ext1_q   <= 1'b0;
            ext2_q   <= 1'b0;
            ext3_q   <= 1'b0;
            fix_q    <= 1'b0;
        end else begin
            st_q     <= st_d;
            wait_q   <= wait_d;
            rdat_q   <= rdat_d;
            ovf_q    <= ovf_d;
            arm_q    <= arm_d;
            oie_q    <= oie_d;
            cas_q    <= cas_d;
            cks_q    <= cks_d;
            ps_q     <= ps_d;
            mod_q    <= mod_d;
            cnt_q    <= cnt_d;
            dir_q    <= dir_d;
            pre_q    <= pre_d;
            lat_q    <= lat_d;
            rem_hi_q <= rem_hi_d;
            buf_q    <= buf_d;
            evt_q    <= evt_d;
            irq_q    <= irq_d;
            // RQ9 two-flop sync
            ext1_q   <= EXT_CLK;
            ext2_q   <= ext1_q;
            ext3_q   <= ext2_q;
            fix_q    <= FIXED_CLK_TICK;
        end
    end

    assign AVS_READDATA    = rdat_q;
    assign AVS_WAITREQUEST = wait_q;
    assign COUNT           = cnt_q;
    assign COUNT_DOWN      = dir_q;
    assign OVERFLOW_EVENT  = evt_q;
    assign OVERFLOW_IRQ    = irq_q;
    assign CENTER_ALIGN    = cas_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_arm;
        take_rd && sel == tcc_pkg::TCC_SEL_SC && ovf_q;
    endsequence
    sequence s_zero_wr;
        wr_sc && !AVS_WRITEDATA[`TCC_SC_OVF] && !wrap;
    endsequence
    property p_wrap_sets;
        @(posedge CLOCK) disable iff (!RST_N)
        wrap |=> ovf_q && OVERFLOW_EVENT ##1 !OVERFLOW_EVENT;
    endproperty
    a_wrap_sets: assert property (p_wrap_sets) else $error("wrap lost"); // RQ1
    property p_clear;
        @(posedge CLOCK) disable iff (!RST_N)
        s_arm ##0 !wrap ##1 (!wrap) [*2] ##1 s_zero_wr |=> !ovf_q;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared"); // RQ2
    property p_restart;
        @(posedge CLOCK) disable iff (!RST_N)
        wrap |=> ovf_q && !arm_q;
    endproperty
    a_restart: assert property (p_restart) else $error("clear not restarted"); // RQ3
    property p_one_ignored;
        @(posedge CLOCK) disable iff (!RST_N)
        wr_sc && AVS_WRITEDATA[`TCC_SC_OVF] && !wrap |=> ovf_q == $past(ovf_q);
    endproperty
    a_one_ignored: assert property (p_one_ignored) else $error("flag moved"); // RQ4
    property p_irq;
        @(posedge CLOCK) disable iff (!RST_N)
        OVERFLOW_IRQ == (ovf_q && oie_q);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch"); // RQ5
    property p_off_holds;
        @(posedge CLOCK) disable iff (!RST_N)
        cks_q == `TCC_CKS_OFF && !wr_cnt |=> cnt_q == $past(cnt_q);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("count moved"); // RQ7
    property p_div1;
        @(posedge CLOCK) disable iff (!RST_N)
        cks_q == `TCC_CKS_BUS && ps_q == '0 && !DEBUG_ACTIVE && !wr_cnt
            |=> cnt_q != $past(cnt_q);
    endproperty
    a_div1: assert property (p_div1) else $error("no count"); // RQ10
    property p_latch;
        @(posedge CLOCK) disable iff (!RST_N)
        take_rd && sel == tcc_pkg::TCC_SEL_CNTH && !lat_q && !DEBUG_ACTIVE
            |=> lat_q && buf_q == $past(cnt_q) && !rem_hi_q;
    endproperty
    a_latch: assert property (p_latch) else $error("latch wrong"); // RQ13
    property p_cnt_wr;
        @(posedge CLOCK) disable iff (!RST_N)
        wr_cnt |=> cnt_q == '0 && !lat_q;
    endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("count not cleared"); // RQ15
    property p_freeze;
        @(posedge CLOCK) disable iff (!RST_N)
        DEBUG_ACTIVE && !wr_cnt |=> cnt_q == $past(cnt_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("count in debug"); // RQ17
    property p_dbg_latch;
        @(posedge CLOCK) disable iff (!RST_N)
        DEBUG_ACTIVE && !wr_sc && !wr_cnt |=> lat_q == $past(lat_q);
    endproperty
    a_dbg_latch: assert property (p_dbg_latch) else $error("latch moved"); // RQ18
    property p_modulo;
        @(posedge CLOCK) disable iff (!RST_N)
        cnt_tick && !cas_q && cnt_q == top && !wr_cnt |=> cnt_q == '0 && OVERFLOW_EVENT;
    endproperty
    a_modulo: assert property (p_modulo) else $error("no restart"); // RQ20

endmodule : tcc_core

`default_nettype wire

// file: test/tcc_core_bench.sv
`include "tcc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module tcc_core_bench;
    logic        clock;
    logic        rst_n;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        debug_active;
    logic        fixed_clk_tick;
    logic        ext_clk;
    logic [15:0] count;
    logic        count_down;
    logic        overflow_event;
    logic        overflow_irq;
    logic        center_align;
    logic [1:0]  ext_div;
    int          n_fail;
    int          n_compared;
    int          gap;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic [31:0] lo;
    logic [15:0] c_a;

    tcc_core uut (
        .CLOCK           (clock),
        .RST_N           (rst_n),
        .AVS_ADDRESS     (avs_address),
        .AVS_READ        (avs_read),
        .AVS_WRITE       (avs_write),
        .AVS_WRITEDATA   (avs_writedata),
        .AVS_BYTEENABLE  (avs_byteenable),
        .AVS_READDATA    (avs_readdata),
        .AVS_WAITREQUEST (avs_waitrequest),
        .DEBUG_ACTIVE    (debug_active),
        .FIXED_CLK_TICK  (fixed_clk_tick),
        .EXT_CLK         (ext_clk),
        .COUNT           (count),
        .COUNT_DOWN      (count_down),
        .OVERFLOW_EVENT  (overflow_event),
        .OVERFLOW_IRQ    (overflow_irq),
        .CENTER_ALIGN    (center_align)
    );

    // ----------------------------------------
    // Clock, external source, watchdog
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // External source at bus/8
    always @(posedge clock) begin
        ext_div <= ext_div + 2'h1;
        if (ext_div == 2'h3) begin
            ext_clk <= ~ext_clk;
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        report_and_stop();
    end

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic bus_cycle(input logic wr, input logic [3:0] addr,
                             input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge clock);
        avs_address   <= addr;
        avs_writedata <= wdata;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus_cycle

    task automatic reg_wr(input logic [3:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        bus_cycle(1'b1, addr, data, unused);
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] addr, output logic [31:0] data);
        bus_cycle(1'b0, addr, 32'h0000_0000, data);
    endtask : reg_rd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Counter advance over n cycles after settling
    task automatic delta(input int n, output logic [15:0] d);
        logic [15:0] a;
        repeat (16) @(posedge clock);
        a = count;
        repeat (n) @(posedge clock);
        d = count - a;
    endtask : delta

    // Cycles until the next overflow pulse
    task automatic wait_ovf(output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (overflow_event !== 1'b1);
    endtask : wait_ovf

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        n_fail = 0;
        n_compared = 0;
        rst_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        debug_active = 1'b0;
        fixed_clk_tick = 1'b0;
        ext_clk = 1'b0;
        ext_div = 2'h0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;

        reg_rd(`TCC_OFS_SC, rd);
        check(rd, 32'h0000_0000);
        check({16'h0000, count}, 32'h0000_0000);
        check({31'h0, overflow_irq}, 32'h0000_0000);
        $display("test reset done");

        for (int s = 0; s < 4; s++) begin
            reg_wr(`TCC_OFS_CNTL, 32'h0000_0000);
            reg_wr(`TCC_OFS_SC, {24'h0, 3'h0, 2'(s), 3'h0});
            delta(64, c_a);
            check({16'h0, c_a}, (s == 0) ? 32'h0 : (s == 3) ? 32'h8 : 32'h40);
        end
        $display("test clock source done");

        for (int p = 0; p < 8; p++) begin
            reg_wr(`TCC_OFS_SC, {24'h0, 5'h01, 3'(p)});
            delta(8 << p, c_a);
            check({16'h0, c_a}, 32'h0000_0008);
        end
        $display("test prescale done");

        reg_wr(`TCC_OFS_MOD, 32'h0000_0005);
        reg_rd(`TCC_OFS_MOD, rd);
        check(rd, 32'h0000_0005);
        reg_wr(`TCC_OFS_CNTL, 32'h0000_0000);
        reg_wr(`TCC_OFS_SC, 32'h0000_0048);
        wait_ovf(gap);
        check({16'h0, count}, 32'h0000_0000);
        wait_ovf(gap);
        check(32'(gap), 32'h0000_0006);
        check({31'h0, overflow_irq}, 32'h0000_0001);
        reg_rd(`TCC_OFS_SC, rd);
        wait_ovf(gap);
        reg_wr(`TCC_OFS_SC, 32'h0000_0048);
        reg_rd(`TCC_OFS_SC, rd);
        check({31'h0, rd[7]}, 32'h0000_0001);
        reg_wr(`TCC_OFS_SC, 32'h0000_0068);
        check({31'h0, center_align}, 32'h0000_0001);
        wait_ovf(gap);
        wait_ovf(gap);
        check(32'(gap), 32'h0000_000A);
        repeat (7) @(posedge clock);
        check({15'h0, count_down, count}, 32'h0001_0003);
        $display("test overflow done");

        reg_wr(`TCC_OFS_SC, 32'h0000_00C0);
        reg_wr(`TCC_OFS_SC, 32'h0000_0000);
        check({31'h0, overflow_irq}, 32'h0000_0000);
        reg_rd(`TCC_OFS_SC, rd);
        check(rd, 32'h0000_0080);
        reg_wr(`TCC_OFS_SC, 32'h0000_0040);
        reg_rd(`TCC_OFS_SC, rd);
        check(rd, 32'h0000_0040);
        check({31'h0, overflow_irq}, 32'h0000_0000);
        $display("test flag clear done");

        reg_wr(`TCC_OFS_MOD, 32'h0000_0000);
        reg_wr(`TCC_OFS_SC, 32'h0000_0008);
        repeat (600) @(posedge clock);
        reg_rd(`TCC_OFS_CNTH, rd);
        repeat (600) @(posedge clock);
        reg_rd(`TCC_OFS_CNTH, rd2);
        check(rd2, rd);
        debug_active <= 1'b1;
        reg_rd(`TCC_OFS_CNTL, lo);
        reg_rd(`TCC_OFS_CNTL, rd2);
        check(rd2, lo);
        debug_active <= 1'b0;
        reg_rd(`TCC_OFS_CNTH, rd2);
        check(rd2, rd);
        reg_rd(`TCC_OFS_CNTL, rd2);
        check(rd2, lo);
        reg_rd(`TCC_OFS_CNTH, rd2);
        check({31'h0, rd2 !== rd}, 32'h0000_0001);
        repeat (600) @(posedge clock);
        reg_wr(`TCC_OFS_SC, 32'h0000_0008);
        reg_rd(`TCC_OFS_CNTH, rd);
        check({31'h0, rd !== rd2}, 32'h0000_0001);
        repeat (600) @(posedge clock);
        debug_active <= 1'b1;
        reg_wr(`TCC_OFS_SC, 32'h0000_0008);
        reg_rd(`TCC_OFS_CNTH, rd2);
        check({31'h0, rd2 !== rd}, 32'h0000_0001);
        c_a = count;
        repeat (50) @(posedge clock);
        check({16'h0, count}, {16'h0, c_a});
        debug_active <= 1'b0;
        reg_wr(`TCC_OFS_SC, 32'h0000_0000);
        reg_wr(`TCC_OFS_CNTH, 32'h0000_00FF);
        reg_rd(`TCC_OFS_CNTH, rd);
        reg_rd(`TCC_OFS_CNTL, rd2);
        check({rd[15:0], rd2[15:0]}, 32'h0000_0000);
        check({16'h0, count}, 32'h0000_0000);
        $display("test counter read done");

        report_and_stop();
    end
endmodule : tcc_core_bench

`default_nettype wire
